// *** design/rhf_pkg.sv ***
// Shared constants for the receive packet FIFO read-out block.
// Assumes register indices are word indices on APB (byte address = 4 x index).
`default_nettype none

package rhf_pkg;

    // Word indices of the port-one register block; later ports add one stride each.
    localparam logic [13:0] REG_BLOCK_INDEX      = 14'h1510;
    localparam logic [13:0] REG_CTRL_INDEX       = 14'h1510;
    localparam logic [13:0] REG_LEVEL_INDEX      = 14'h1511;
    localparam logic [13:0] REG_LIVE_INDEX       = 14'h1514;
    localparam logic [13:0] REG_LATCH_INDEX      = 14'h1516;
    localparam logic [13:0] REG_IRQ_EN_INDEX     = 14'h1518;
    localparam logic [13:0] REG_ENTRY_STAT_INDEX = 14'h151C;
    localparam logic [13:0] REG_DATA_INDEX       = 14'h151D;
    localparam logic [13:0] REG_PORT_STRIDE      = 14'h0020;

    // Offsets inside one port block, derived from the indices above.
    localparam logic [4:0] OFS_CTRL       = 5'(REG_CTRL_INDEX - REG_BLOCK_INDEX);
    localparam logic [4:0] OFS_LEVEL      = 5'(REG_LEVEL_INDEX - REG_BLOCK_INDEX);
    localparam logic [4:0] OFS_LIVE       = 5'(REG_LIVE_INDEX - REG_BLOCK_INDEX);
    localparam logic [4:0] OFS_LATCH      = 5'(REG_LATCH_INDEX - REG_BLOCK_INDEX);
    localparam logic [4:0] OFS_IRQ_EN     = 5'(REG_IRQ_EN_INDEX - REG_BLOCK_INDEX);
    localparam logic [4:0] OFS_ENTRY_STAT = 5'(REG_ENTRY_STAT_INDEX - REG_BLOCK_INDEX);
    localparam logic [4:0] OFS_DATA       = 5'(REG_DATA_INDEX - REG_BLOCK_INDEX);

    // Event bit positions, shared by the latched and the enable registers.
    localparam int BIT_OVERFLOW  = 7;
    localparam int BIT_PKT_END   = 4;
    localparam int BIT_PKT_START = 3;
    localparam int BIT_FULL      = 2;
    localparam int BIT_AVAIL     = 0;
    localparam logic [7:0] EVENT_MASK = 8'h9D;

    // Control bits: bit reordering and FIFO flush.
    localparam int CTRL_REORDER_BIT = 3;
    localparam int CTRL_FLUSH_BIT   = 0;
    localparam logic [7:0] CTRL_MASK = 8'h09;

    // Live status bit positions.
    localparam int LIVE_FULL_BIT  = 2;
    localparam int LIVE_EMPTY_BIT = 1;
    localparam int LIVE_AVAIL_BIT = 0;

    // Values after reset.
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] IRQ_EN_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET  = 8'h00;
    localparam logic [4:0] LEVEL_RESET  = 5'h08;

    // The availability level counts groups of this many bytes (as a shift).
    localparam int LEVEL_GROUP_SHIFT = 3;

    // Packet status codes carried with every stored byte.
    localparam logic [2:0] PS_MIDDLE    = 3'h0;
    localparam logic [2:0] PS_START     = 3'h1;
    localparam logic [2:0] PS_END_GOOD  = 3'h4;
    localparam logic [2:0] PS_END_FCS   = 3'h5;
    localparam logic [2:0] PS_END_BYTES = 3'h6;
    localparam logic [2:0] PS_END_ABORT = 3'h7;
    localparam int PS_END_FLAG_BIT = 2;

endpackage

`default_nettype wire

// *** design/rhf_mem.sv ***
// Shared byte store for all receive FIFOs, one write and one read port.
// Assumes the caller never reads and writes the same word in one cycle.
`default_nettype none

module rhf_mem #(
    parameter int WIDTH  = 11,
    parameter int DEPTH  = 2048,
    parameter int ADDR_W = $clog2(DEPTH)
) (
    // Clock and freeze.
    input  wire logic              clk,
    input  wire logic              ce,
    // Write side.
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]  wr_data,
    // Read side; data appear one edge after the request.
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [WIDTH-1:0]  rd_data
);

    // The array has no reset, so it maps onto plain RAM.
    logic [WIDTH-1:0] store [DEPTH];

    // Write and registered read; both hold still while the clock enable is low.
    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            store[wr_addr] <= wr_data;
        end
        if (ce && rd_en) begin
            rd_data <= store[rd_addr];
        end
    end

endmodule

`default_nettype wire

// *** design/rhf_readout.sv ***
// Receive packet FIFO read-out for several ports behind one APB slave.
// Assumes the write side and APB run on CLK_SYS; no input needs a synchroniser.
//
// Decided for this implementation: the APB register port.
`default_nettype none

module rhf_readout
    import rhf_pkg::*;
#(
    parameter int NP    = 8,
    parameter int DEPTH = 256
) (
    // Clock, reset and freeze.
    input  wire logic          CLK_SYS,
    input  wire logic          RST,
    input  wire logic          CE,
    // APB slave.
    input  wire logic          PSEL,
    input  wire logic          PENABLE,
    input  wire logic          PWRITE,
    input  wire logic [15:0]   PADDR,
    input  wire logic [31:0]   PWDATA,
    input  wire logic [3:0]    PSTRB,
    output logic      [31:0]   PRDATA,
    output logic               PREADY,
    output logic               PSLVERR,
    // Receiver write side, one byte per cycle for the port named.
    input  wire logic          WR_VALID,
    input  wire logic [2:0]    WR_PORT,
    input  wire logic [7:0]    WR_BYTE,
    input  wire logic [2:0]    WR_CODE,
    // Status and interrupts.
    output logic      [NP-1:0] FIFO_FULL,
    output logic      [NP-1:0] IRQ_PORT,
    output logic               IRQ
);

    localparam int AW     = $clog2(DEPTH);
    localparam int PORT_W = $clog2(NP);
    localparam int MEM_AW = PORT_W + AW;
    localparam int MEM_W  = 11;

    // Port count is bounded by the three-bit WR_PORT field of the write side.
    if (NP < 2 || NP > 8 || DEPTH < 256 || (1 << AW) != DEPTH) begin : g_check
        $error("rhf_readout: NP must be 2..8 and DEPTH a power of two of 256 or more");
    end

    // All state of the block in one record.
    typedef struct packed {
        logic [NP-1:0][7:0]    irq_en;      // Interrupt enables per port.
        logic [NP-1:0][7:0]    latched;     // Sticky event bits per port.
        logic [NP-1:0][7:0]    ctrl;        // Reorder and flush control.
        logic [NP-1:0][4:0]    level;       // Availability level in byte groups.
        logic [NP-1:0][AW-1:0] wr_ptr;      // Next free slot.
        logic [NP-1:0][AW-1:0] rd_ptr;      // Oldest stored slot.
        logic [NP-1:0][AW:0]   cnt;         // Bytes still in the store.
        logic [NP-1:0][7:0]    head_byte;   // Byte the next data read returns.
        logic [NP-1:0][2:0]    head_code;   // Its packet status code.
        logic [NP-1:0]         head_valid;  // Head entry holds a byte.
        logic [NP-1:0]         full_q;      // Live full, one cycle old.
        logic [NP-1:0]         avail_q;     // Live available, one cycle old.
        logic [NP-1:0]         irq_port;    // Per-port interrupt request.
        logic                  fetch_pend;  // Store read in flight.
        logic [PORT_W-1:0]     fetch_port;  // Port that read belongs to.
        logic                  pop_ok;      // Current data read may pop.
        logic                  irq;         // Any port interrupt.
        logic [31:0]           prdata;      // Read answer.
        logic                  pready;      // Access phase completes.
        logic                  pslverr;     // Address fell outside the map.
    } rhf_state_t;

    rhf_state_t st;       // Registered state.
    rhf_state_t next_st;  // Value for the next edge.

    // Combinational views used by the state update and the checks.
    logic [NP-1:0][AW:0]  total;       // Bytes held per port, head included.
    logic [NP-1:0]        live_full;   // Port cannot take another byte.
    logic [NP-1:0]        live_avail;  // Fill has reached the level.
    logic [13:0]          rel_index;   // Word index relative to the block base.
    logic [PORT_W-1:0]    bus_port;    // Port addressed by APB.
    logic [4:0]           bus_off;     // Register inside that port block.
    logic                 bus_hit;     // Address falls inside the map.
    logic [7:0]           sel_byte;    // Head byte of the addressed port.
    logic [7:0]           rev_byte;    // Same byte with bit order reversed.
    logic [7:0]           rd8;         // Read answer before widening.
    logic [2:0]           wr_code_ok;  // Incoming code with reserved values removed.
    logic                 fetch_found; // A refill was chosen this cycle.
    logic                 mem_wr_en;   // Store write strobe.
    logic [MEM_AW-1:0]    mem_wr_addr; // Store write address.
    logic                 mem_rd_en;   // Store read strobe.
    logic [MEM_AW-1:0]    mem_rd_addr; // Store read address.
    logic [MEM_W-1:0]     mem_rd_data; // Registered store output.

    // One store serves every port; each port owns a slice of DEPTH words.
    rhf_mem #(
        .WIDTH  (MEM_W),
        .DEPTH  (1 << MEM_AW),
        .ADDR_W (MEM_AW)
    ) u_mem (
        .clk     (CLK_SYS),
        .ce      (CE),
        .wr_en   (mem_wr_en),
        .wr_addr (mem_wr_addr),
        .wr_data ({wr_code_ok, WR_BYTE}),
        .rd_en   (mem_rd_en),
        .rd_addr (mem_rd_addr),
        .rd_data (mem_rd_data)
    );

    // Fill levels per port; a byte in flight from the store still counts.
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            total[p] = st.cnt[p] + (AW + 1)'(st.head_valid[p])
                     + (AW + 1)'(st.fetch_pend && (st.fetch_port == PORT_W'(p)));
            live_full[p]  = (int'(total[p]) >= DEPTH);
            live_avail[p] = (total[p] != '0)
                         && (int'(total[p]) >= (int'(st.level[p]) << LEVEL_GROUP_SHIFT));
        end
    end

    // Address decode; each port block repeats at a fixed stride.
    always_comb begin
        rel_index = PADDR[15:2] - REG_BLOCK_INDEX;
        bus_port  = rel_index[5 +: PORT_W];
        bus_off   = rel_index[4:0];
        bus_hit   = (PADDR[15:2] >= REG_BLOCK_INDEX) && (PADDR[1:0] == 2'h0)
                 && (int'(rel_index[13:5]) < NP);
        sel_byte  = st.head_byte[bus_port];
        rev_byte  = '0;
        for (int b = 0; b < 8; b++) begin
            rev_byte[b] = sel_byte[7 - b];
        end
        // Reserved codes are folded into mid-packet so they never reach software.
        wr_code_ok = (WR_CODE[2:1] == 2'b01) ? PS_MIDDLE : WR_CODE;
    end

    // Read mux; reserved words inside a block answer zero without error.
    always_comb begin
        unique case (bus_off)
            OFS_CTRL:       rd8 = st.ctrl[bus_port] & CTRL_MASK;
            OFS_LEVEL:      rd8 = {3'h0, st.level[bus_port]};
            OFS_LIVE:       rd8 = {5'h00, live_full[bus_port],
                                   total[bus_port] == '0, live_avail[bus_port]};
            OFS_LATCH:      rd8 = st.latched[bus_port];
            OFS_IRQ_EN:     rd8 = st.irq_en[bus_port];
            OFS_ENTRY_STAT: rd8 = {4'h0, st.head_code[bus_port],
                                   st.head_valid[bus_port]};
            OFS_DATA:       rd8 = st.ctrl[bus_port][CTRL_REORDER_BIT]
                                  ? rev_byte : sel_byte;
            default:        rd8 = 8'h00;
        endcase
    end

    // Next-state logic: flush, refill, bus, write side, events, interrupts.
    always_comb begin
        next_st     = st;
        fetch_found = 1'b0;
        mem_rd_en   = 1'b0;
        mem_rd_addr = '0;
        mem_wr_en   = 1'b0;
        mem_wr_addr = '0;

        // A flushing port is held empty and keeps no head byte.
        for (int p = 0; p < NP; p++) begin
            if (st.ctrl[p][CTRL_FLUSH_BIT]) begin
                next_st.wr_ptr[p]     = '0;
                next_st.rd_ptr[p]     = '0;
                next_st.cnt[p]        = '0;
                next_st.head_valid[p] = 1'b0;
            end
        end

        // A store read issued last cycle lands in its port's head entry.
        if (st.fetch_pend) begin
            next_st.fetch_pend = 1'b0;
            if (!st.ctrl[st.fetch_port][CTRL_FLUSH_BIT]) begin
                next_st.head_byte[st.fetch_port]  = mem_rd_data[7:0];
                next_st.head_code[st.fetch_port]  = mem_rd_data[10:8];
                next_st.head_valid[st.fetch_port] = 1'b1;
            end
        end

        // Refill the lowest port whose head is empty; one read in flight at most.
        for (int p = 0; p < NP; p++) begin
            if (!fetch_found && !st.fetch_pend && !st.head_valid[p]
                && (st.cnt[p] != '0) && !st.ctrl[p][CTRL_FLUSH_BIT]) begin
                fetch_found        = 1'b1;
                mem_rd_en          = 1'b1;
                mem_rd_addr        = {PORT_W'(p), st.rd_ptr[p]};
                next_st.rd_ptr[p]  = st.rd_ptr[p] + AW'(1);
                next_st.cnt[p]     = st.cnt[p] - (AW + 1)'(1);
                next_st.fetch_pend = 1'b1;
                next_st.fetch_port = PORT_W'(p);
            end
        end

        // APB: the answer is prepared in the first access cycle.
        if (PSEL && PENABLE && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = !bus_hit;
            next_st.prdata  = (bus_hit && !PWRITE) ? {24'h000000, rd8} : 32'h00000000;
            // A pop is allowed only for the byte that is being returned.
            next_st.pop_ok  = bus_hit && !PWRITE && (bus_off == OFS_DATA)
                           && st.head_valid[bus_port];
        end

        // The transfer completes where the master samples PREADY high.
        if (PSEL && PENABLE && st.pready) begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
            next_st.pop_ok  = 1'b0;
            if (PWRITE && bus_hit && PSTRB[0]) begin
                unique case (bus_off)
                    OFS_CTRL:   next_st.ctrl[bus_port]   = PWDATA[7:0] & CTRL_MASK;
                    OFS_LEVEL:  next_st.level[bus_port]  = PWDATA[4:0];
                    OFS_LATCH:  next_st.latched[bus_port] =
                                    st.latched[bus_port] & ~(PWDATA[7:0] & EVENT_MASK);
                    OFS_IRQ_EN: next_st.irq_en[bus_port] = PWDATA[7:0] & EVENT_MASK;
                    default:    next_st.ctrl[bus_port]   = next_st.ctrl[bus_port];
                endcase
            end
            // Only the data word pops; the status word has no side effect.
            if (!PWRITE && st.pop_ok && (bus_off == OFS_DATA)) begin
                next_st.head_valid[bus_port] = 1'b0;
            end
        end

        // Write side; events set after the software clear, so a set wins.
        if (WR_VALID && (int'(WR_PORT) < NP) && !st.ctrl[WR_PORT][CTRL_FLUSH_BIT]) begin
            if (live_full[WR_PORT]) begin
                // The byte is dropped; software learns of it from the latch.
                next_st.latched[WR_PORT][BIT_OVERFLOW] = 1'b1;
            end else begin
                mem_wr_en               = 1'b1;
                mem_wr_addr             = {WR_PORT[PORT_W-1:0], st.wr_ptr[WR_PORT]};
                next_st.wr_ptr[WR_PORT] = st.wr_ptr[WR_PORT] + AW'(1);
                next_st.cnt[WR_PORT]    = next_st.cnt[WR_PORT] + (AW + 1)'(1);
                if (wr_code_ok == PS_START) begin
                    next_st.latched[WR_PORT][BIT_PKT_START] = 1'b1;
                end
                if (wr_code_ok[PS_END_FLAG_BIT]) begin
                    next_st.latched[WR_PORT][BIT_PKT_END] = 1'b1;
                end
            end
        end

        // Edge events on the live flags, then the per-port interrupt requests.
        for (int p = 0; p < NP; p++) begin
            if (live_full[p] && !st.full_q[p]) begin
                next_st.latched[p][BIT_FULL] = 1'b1;
            end
            if (live_avail[p] && !st.avail_q[p]) begin
                next_st.latched[p][BIT_AVAIL] = 1'b1;
            end
            next_st.full_q[p]   = live_full[p];
            next_st.avail_q[p]  = live_avail[p];
            next_st.irq_port[p] = |(next_st.latched[p] & next_st.irq_en[p]
                                    & EVENT_MASK);
        end
        next_st.irq = |next_st.irq_port;
    end

    // State register; RST still acts, otherwise everything holds while CE is low.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st       <= '0;
            st.level <= {NP{LEVEL_RESET}};
        end else if (CE) begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register.
    assign PRDATA    = st.prdata;
    assign PREADY    = st.pready;
    assign PSLVERR   = st.pslverr;
    assign FIFO_FULL = st.full_q;
    assign IRQ_PORT  = st.irq_port;
    assign IRQ       = st.irq;

    // Checks on the registered state.
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST || !CE);

    for (genvar g = 0; g < NP; g++) begin : g_irq_chk
        a_ovf_irq:   assert property (st.latched[g][7] && st.irq_en[g][7] |-> st.irq_port[g])
            else $error("overflow interrupt missing");
        a_end_irq:   assert property (st.latched[g][4] && st.irq_en[g][4] |-> st.irq_port[g])
            else $error("packet end interrupt missing");
        a_start_irq: assert property (st.latched[g][3] && st.irq_en[g][3] |-> st.irq_port[g])
            else $error("packet start interrupt missing");
        a_full_irq:  assert property (st.latched[g][2] && st.irq_en[g][2] |-> st.irq_port[g])
            else $error("full interrupt missing");
        a_avail_irq: assert property (st.latched[g][0] && st.irq_en[g][0] |-> st.irq_port[g])
            else $error("data available interrupt missing");
        a_irq_only:  assert property (st.irq_port[g] |-> |(st.latched[g] & st.irq_en[g]))
            else $error("port interrupt without enabled event");
        a_full_edge: assert property (live_full[g] && !st.full_q[g]
                                      |=> st.latched[g][2])
            else $error("full rising edge not latched");
    end

    a_pop_cause: assert property ($fell(st.head_valid[0]) && !$past(st.ctrl[0][0])
                                  |-> $past(PSEL && st.pready && st.pop_ok && bus_port == 0))
        else $error("head popped without a data read");
    a_stat_pure: assert property (PSEL && st.pready && !PWRITE && bus_hit
                                  && bus_off == OFS_ENTRY_STAT && st.head_valid[bus_port]
                                  |=> st.head_valid[$past(bus_port)])
        else $error("status read disturbed the head entry");
    a_code_legal: assert property (st.head_valid[0] |-> st.head_code[0][2:1] != 2'b01)
        else $error("reserved packet code at head");
    a_stat_code: assert property ($rose(st.pready) && $past(!PWRITE && bus_hit
                                  && bus_off == OFS_ENTRY_STAT)
                                  |-> PRDATA[3:0] == $past({st.head_code[bus_port],
                                                            st.head_valid[bus_port]}))
        else $error("status word does not match head entry");
    a_valid_reset: assert property ($fell(RST) |-> st.head_valid == '0 && st.cnt == '0)
        else $error("data valid not clear after reset");
    a_reorder:   assert property ($rose(st.pready) && $past(!PWRITE && bus_hit
                                  && bus_off == OFS_DATA)
                                  |-> PRDATA[7] == $past(st.ctrl[bus_port][3]
                                                         ? sel_byte[0] : sel_byte[7]))
        else $error("bit order of data byte wrong");
    a_ovf_latch: assert property (WR_VALID && live_full[WR_PORT]
                                  && !st.ctrl[WR_PORT][0]
                                  |=> st.latched[$past(WR_PORT)][7])
        else $error("overflow not latched");
    a_start_latch: assert property (WR_VALID && wr_code_ok == PS_START && !live_full[WR_PORT]
                                    && !st.ctrl[WR_PORT][0]
                                    |=> st.latched[$past(WR_PORT)][3])
        else $error("packet start not latched");
    a_irq_any:   assert property (IRQ == |IRQ_PORT)
        else $error("summary interrupt disagrees with ports");

    c_pop:      cover property (PSEL && st.pready && st.pop_ok);
    c_overflow: cover property (WR_VALID && live_full[WR_PORT]);
    c_irq_rise: cover property ($rose(IRQ));

endmodule

`default_nettype wire

// *** testbench/rhf_host.sv ***
// Host processor model: an APB master that runs one transfer per call.
// Assumes the slave answers with PREADY; the bench watchdog ends a hang.
`default_nettype none
module rhf_host (
    // Clock.
    input  wire logic        clk,
    // APB master side.
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [15:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // The request is held until PREADY is seen at an edge, then released.
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** testbench/rx_hdlc_fifo_readout_tb.sv ***
// Bench for the receive FIFO read-out: pushes bytes, reads them over APB.
// Assumes rhf_host as the APB master and a fixed clock enable.
`default_nettype none
module rx_hdlc_fifo_readout_tb;
    import rhf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, rst = 1'b1, wr_valid = 1'b0, psel, penable, pwrite, pready, pslverr;
    logic [2:0] wr_code = 3'h0;
    logic [7:0] wr_byte = 8'h00, irq_port, fifo_full;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic irq, e;
    int bad_count = 0, checks = 0;
    localparam int FILL = 257; // One byte beyond the 256-byte FIFO, so the last one overflows.
    logic [2:0] codes [6] = '{PS_START, PS_MIDDLE, PS_END_GOOD, PS_END_FCS, PS_END_BYTES,
                              PS_END_ABORT};
    always #50 clk_sys = ~clk_sys;
    rhf_host host (.clk(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    rhf_readout dut (.CLK_SYS(clk_sys), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .WR_VALID(wr_valid), .WR_PORT(3'h0),
        .WR_BYTE(wr_byte), .WR_CODE(wr_code), .FIFO_FULL(fifo_full), .IRQ_PORT(irq_port),
        .IRQ(irq));
    // Compares one value and counts it.
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    // Byte address of a register index for port p (1..8).
    function automatic logic [15:0] ad(input logic [13:0] i, input int p);
        return {i + 14'(p - 1) * REG_PORT_STRIDE, 2'b00};
    endfunction
    // Reads a register and compares the whole 32-bit answer against the expected value.
    task automatic rd(input logic [13:0] i, input int p, input logic [31:0] x, input string n);
        host.xfer(1'b0, ad(i, p), 32'h0, r, e);
        chk(n, x, r);
    endtask
    // Writes a register, then lets one edge pass so outputs settle.
    task automatic wr(input logic [13:0] i, input int p, input logic [7:0] d);
        host.xfer(1'b1, ad(i, p), {24'h0, d}, r, e);
        @(posedge clk_sys);
        #1;
    endtask
    // Pushes one byte into port one and waits for it to reach the head.
    task automatic push(input logic [2:0] c, input logic [7:0] b);
        @(posedge clk_sys);
        wr_valid <= 1'b1;
        wr_code <= c;
        wr_byte <= b;
        @(posedge clk_sys);
        wr_valid <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rd(REG_IRQ_EN_INDEX, 1, 32'h0, "irq_en_reset");
        rd(REG_ENTRY_STAT_INDEX, 1, 32'h0, "stat_reset");
        for (int k = 0; k < 6; k++) begin
            push(codes[k], 8'h30 + 8'(k));
            rd(REG_ENTRY_STAT_INDEX, 1, {28'h0, codes[k], 1'b1}, "stat");
            rd(REG_ENTRY_STAT_INDEX, 1, {28'h0, codes[k], 1'b1}, "stat_again");
            rd(REG_DATA_INDEX, 1, 32'h30 + k, "data");
        end
        repeat (3) @(posedge clk_sys);
        rd(REG_ENTRY_STAT_INDEX, 1, {28'h0, PS_END_ABORT, 1'b0}, "stat_empty");
        wr(REG_CTRL_INDEX, 1, 8'h08);
        push(PS_START, 8'h03);
        rd(REG_ENTRY_STAT_INDEX, 1, {28'h0, PS_START, 1'b1}, "stat_reorder");
        rd(REG_DATA_INDEX, 1, 32'hC0, "data_reorder");
        rd(REG_LATCH_INDEX, 1, 32'h18, "latched");
        chk("irq_off", 1, irq === 1'b0);
        wr(REG_IRQ_EN_INDEX, 1, 8'h10);
        chk("irq_end", 1, irq === 1'b1 && irq_port === 8'h01);
        wr(REG_IRQ_EN_INDEX, 1, 8'h08);
        chk("irq_start", 1, irq === 1'b1);
        wr(REG_IRQ_EN_INDEX, 1, 8'h85);
        chk("irq_masked", 1, irq === 1'b0);
        wr(REG_LATCH_INDEX, 1, 8'h18);
        rd(REG_LATCH_INDEX, 1, 32'h0, "latch_clear");
        wr(REG_IRQ_EN_INDEX, 8, 8'h9D);
        rd(REG_IRQ_EN_INDEX, 8, 32'h9D, "irq_en_p8");
        rd(REG_IRQ_EN_INDEX, 1, 32'h85, "irq_en_p1");
        // Fill port one back to back until the last byte is dropped.
        wr_code <= PS_MIDDLE;
        wr_valid <= 1'b1;
        repeat (FILL) @(posedge clk_sys);
        wr_valid <= 1'b0;
        rd(REG_LIVE_INDEX, 1, 32'h05, "live_full");
        chk("fifo_full", 32'h01, {24'h0, fifo_full});
        rd(REG_LATCH_INDEX, 1, 32'h85, "latched_fill");
        chk("irq_fill", 1, irq === 1'b1 && irq_port === 8'h01);
        // Flush port one; it must read empty with no valid byte.
        wr(REG_CTRL_INDEX, 1, 8'h09);
        rd(REG_LIVE_INDEX, 1, 32'h02, "live_flushed");
        rd(REG_ENTRY_STAT_INDEX, 1, 32'h0, "stat_flushed");
        chk("fifo_flushed", 32'h00, {24'h0, fifo_full});
        host.xfer(1'b0, 16'h0000, 32'h0, r, e);
        chk("unmapped_err", 1, e);
        end_of_test();
    end
endmodule
`default_nettype wire
